// ### clkgate_regs.svh
// Functional notes
// - each differential output has its own software enable bit.
// - each output has its own asynchronous active-low hardware enable pin.
// - software enable bits are active high and reset to enabled.
// - a disabled output drives both legs low.
// - output toggles only with software bit 1 and pin 0.
// - re-enable on pin falling starts the output without runt or glitch.
// - output active 4 to 12 output periods after pin assertion.
// - disable on pin rising stops the output without shortened pulse.
// - at least four complete cycles follow pin deassertion before stopping.
// - output disabled within 12 output periods after pin deassertion.
// - power-down stops all outputs before the oscillator is turned off.
// - power-down acts after two low samples on rising edges, low from next falling.
`ifndef CLKGATE_REGS_SVH
`define CLKGATE_REGS_SVH

// number of differential outputs
`define CLKGATE_NUM_OUTPUTS 6
// output periods waited after an enable is seen before the output starts
`define CLKGATE_ON_DELAY_PERIODS 5
// complete output periods still driven after an enable is withdrawn
`define CLKGATE_DRAIN_PERIODS 5
// width of the period counters
`define CLKGATE_CNT_W 4
// consecutive low samples of power-down on rising output edges
`define CLKGATE_PD_SAMPLES 2
// width of the power-down sample counter
`define CLKGATE_PD_CNT_W 2
// software enable reset value (one bit replicated)
`define CLKGATE_SW_EN_RESET 1'b1

`endif

// ### clkgate_pkg.sv
package clkgate_pkg;

    // per-output gate state
    typedef enum logic [1:0] {
        GATE_OFF,
        GATE_ARMING,
        GATE_ON,
        GATE_DRAINING
    } gate_state_t;

endpackage : clkgate_pkg

// ### pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous level in, filtered level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] agree;

    // a change counts only once the second and third stages agree
    assign agree = ~(stage2_reg ^ stage3_reg);

    // three-stage chain, first stage read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
            stage3_reg <= RESET_VALUE;
            out_reg <= RESET_VALUE;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            out_reg <= (agree & stage3_reg) | (~agree & out_reg);
        end
    end

    assign sync_out = out_reg;

endmodule : pin_sync
`default_nettype wire

// ### output_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkgate_regs.svh"
module output_gate
    import clkgate_pkg::*;
#(
    parameter int CNT_W = `CLKGATE_CNT_W,
    parameter logic [CNT_W-1:0] ON_DELAY = CNT_W'(`CLKGATE_ON_DELAY_PERIODS),
    parameter logic [CNT_W-1:0] DRAIN = CNT_W'(`CLKGATE_DRAIN_PERIODS)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // one pulse per output period, in its last (high) half
    input wire logic period_end,
    // requested enable and forced stop
    input wire logic want_on,
    input wire logic force_off,
    // gate state
    output logic running
);

    gate_state_t state_reg;
    gate_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic running_reg;
    logic running_next;
    logic [CNT_W-1:0] cnt_inc;
    logic arm_done;
    logic drain_done;

    assign cnt_inc = cnt_reg + CNT_W'(1);
    assign arm_done = period_end && (cnt_inc == ON_DELAY);
    assign drain_done = period_end && (cnt_inc == DRAIN);

    // gate sequencing; running changes only at a period end, while the leg is low next
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        running_next = running_reg;
        unique case (state_reg)
            GATE_OFF: begin
                cnt_next = '0;
                if (want_on && !force_off) begin
                    state_next = GATE_ARMING;
                end
            end
            GATE_ARMING: begin
                if (!want_on || force_off) begin
                    state_next = GATE_OFF;
                    cnt_next = '0;
                end else if (arm_done) begin
                    state_next = GATE_ON;
                    running_next = 1'b1;
                    cnt_next = '0;
                end else if (period_end) begin
                    cnt_next = cnt_inc;
                end
            end
            GATE_ON: begin
                cnt_next = '0;
                if (force_off && period_end) begin
                    state_next = GATE_OFF;
                    running_next = 1'b0;
                end else if (!want_on && !force_off) begin
                    state_next = GATE_DRAINING;
                end
            end
            GATE_DRAINING: begin
                if (force_off && period_end) begin
                    state_next = GATE_OFF;
                    running_next = 1'b0;
                    cnt_next = '0;
                end else if (want_on && !force_off) begin
                    state_next = GATE_ON;
                    cnt_next = '0;
                end else if (drain_done) begin
                    state_next = GATE_OFF;
                    running_next = 1'b0;
                    cnt_next = '0;
                end else if (period_end) begin
                    cnt_next = cnt_inc;
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= GATE_OFF;
            cnt_reg <= '0;
            running_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            running_reg <= running_next;
        end
    end

    assign running = running_reg;

endmodule : output_gate
`default_nettype wire

// ### clock_output_enable_gating.sv
`timescale 1ns/1ps
`default_nettype none
`include "clkgate_regs.svh"
module clock_output_enable_gating
    import clkgate_pkg::*;
#(
    parameter int NUM_OUTPUTS = `CLKGATE_NUM_OUTPUTS
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // hardware enables, one per output, active low, asynchronous
    input wire logic [NUM_OUTPUTS-1:0] OUTPUT_ENABLE_N,
    // power-down, active low, asynchronous
    input wire logic POWER_DOWN_N,
    // software enable bits, loaded on the write strobe
    input wire logic SW_ENABLE_WE,
    input wire logic [NUM_OUTPUTS-1:0] SW_ENABLE_DATA,
    output logic [NUM_OUTPUTS-1:0] SW_ENABLE_STATUS,
    // differential clock outputs
    output logic [NUM_OUTPUTS-1:0] DIFF_CLK_P,
    output logic [NUM_OUTPUTS-1:0] DIFF_CLK_N,
    // output state and oscillator control
    output logic [NUM_OUTPUTS-1:0] OUTPUT_RUNNING,
    output logic OSC_ENABLE
);

    logic phase_reg;
    logic [NUM_OUTPUTS-1:0] sw_en_reg;
    logic [NUM_OUTPUTS-1:0] oe_n_sync;
    logic pd_n_sync;
    logic [`CLKGATE_PD_CNT_W-1:0] pd_cnt_reg;
    logic [`CLKGATE_PD_CNT_W-1:0] pd_cnt_next;
    logic pd_hold_reg;
    logic pd_hold_next;
    logic osc_en_reg;
    logic [NUM_OUTPUTS-1:0] running;
    logic [NUM_OUTPUTS-1:0] want_on;
    logic [NUM_OUTPUTS-1:0] p_reg;
    logic [NUM_OUTPUTS-1:0] n_reg;
    logic [NUM_OUTPUTS-1:0] run_reg;
    logic period_end;
    logic rising_edge_slot;
    logic all_stopped;

    // output period is two MCLK cycles; high half is phase_reg == 1
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end

    // falling output edge follows the high half, rising edge follows the low half
    assign period_end = phase_reg;
    assign rising_edge_slot = ~phase_reg;

    // software enable bits, one per output, enabled after reset
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sw_en_reg <= {NUM_OUTPUTS{`CLKGATE_SW_EN_RESET}};
        end else if (SW_ENABLE_WE) begin
            sw_en_reg <= SW_ENABLE_DATA;
        end
    end

    // hardware enable pins into the MCLK domain
    pin_sync #(
        .WIDTH(NUM_OUTPUTS),
        .RESET_VALUE({NUM_OUTPUTS{1'b1}})
    ) u_oe_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .async_in(OUTPUT_ENABLE_N),
        .sync_out(oe_n_sync)
    );

    // power-down pin into the MCLK domain
    pin_sync #(
        .WIDTH(1),
        .RESET_VALUE(1'b1)
    ) u_pd_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .async_in(POWER_DOWN_N),
        .sync_out(pd_n_sync)
    );

    // power-down qualification: low on consecutive rising-edge samples
    always_comb begin
        pd_cnt_next = pd_cnt_reg;
        pd_hold_next = pd_hold_reg;
        if (pd_n_sync) begin
            pd_cnt_next = '0;
            pd_hold_next = 1'b0;
        end else if (rising_edge_slot && !pd_hold_reg) begin
            if (pd_cnt_reg == `CLKGATE_PD_CNT_W'(`CLKGATE_PD_SAMPLES - 1)) begin
                pd_hold_next = 1'b1;
                pd_cnt_next = '0;
            end else begin
                pd_cnt_next = pd_cnt_reg + `CLKGATE_PD_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pd_cnt_reg <= '0;
            pd_hold_reg <= 1'b0;
        end else begin
            pd_cnt_reg <= pd_cnt_next;
            pd_hold_reg <= pd_hold_next;
        end
    end

    // output wanted only with software bit 1, pin 0 and no power-down
    assign want_on = sw_en_reg & ~oe_n_sync & {NUM_OUTPUTS{~pd_hold_reg}};

    // one gate per output
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUTPUTS; gi++) begin : g_gate
            output_gate u_gate (
                .clk(MCLK),
                .rst_n(RST_N),
                .period_end(period_end),
                .want_on(want_on[gi]),
                .force_off(pd_hold_reg),
                .running(running[gi])
            );
        end
    endgenerate

    // oscillator stays on until every output has stopped
    assign all_stopped = ~|running & ~|run_reg;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            osc_en_reg <= 1'b1;
        end else if (!pd_hold_reg) begin
            osc_en_reg <= 1'b1;
        end else if (all_stopped) begin
            osc_en_reg <= 1'b0;
        end
    end

    // output legs: complementary while running, both low while stopped
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            p_reg <= '0;
            n_reg <= '0;
            run_reg <= '0;
        end else begin
            p_reg <= running & {NUM_OUTPUTS{phase_reg}};
            n_reg <= running & {NUM_OUTPUTS{~phase_reg}};
            run_reg <= running;
        end
    end

    assign DIFF_CLK_P = p_reg;
    assign DIFF_CLK_N = n_reg;
    assign OUTPUT_RUNNING = run_reg;
    assign SW_ENABLE_STATUS = sw_en_reg;
    assign OSC_ENABLE = osc_en_reg;

endmodule : clock_output_enable_gating
`default_nettype wire

// ### clock_output_enable_gating_props.sv
`timescale 1ns/1ps
`default_nettype none
module clock_output_enable_gating_props #(
    parameter int NUM_OUTPUTS = 6
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // watched ports
    input wire logic [NUM_OUTPUTS-1:0] OUTPUT_ENABLE_N,
    input wire logic POWER_DOWN_N,
    input wire logic SW_ENABLE_WE,
    input wire logic [NUM_OUTPUTS-1:0] SW_ENABLE_DATA,
    input wire logic [NUM_OUTPUTS-1:0] SW_ENABLE_STATUS,
    input wire logic [NUM_OUTPUTS-1:0] DIFF_CLK_P,
    input wire logic [NUM_OUTPUTS-1:0] DIFF_CLK_N,
    input wire logic [NUM_OUTPUTS-1:0] OUTPUT_RUNNING,
    input wire logic OSC_ENABLE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic en0;
    logic [5:0] on_reg;
    logic [5:0] off_reg;
    logic [4:0] pd_reg;
    // enable condition of output 0
    assign en0 = !OUTPUT_ENABLE_N[0] && SW_ENABLE_STATUS[0] && POWER_DOWN_N;
    // saturating counts of how long each condition has held
    always_ff @(posedge MCLK) begin
        on_reg <= (!RST_N || !en0) ? 6'h00 : on_reg + {5'h00, on_reg != 6'h3f};
        off_reg <= (!RST_N || en0) ? 6'h00 : off_reg + {5'h00, off_reg != 6'h3f};
        pd_reg <= (!RST_N || POWER_DOWN_N) ? 5'h00 : pd_reg + {4'h0, pd_reg != 5'h1f};
    end
    property p_sw_write;
        SW_ENABLE_WE |=> SW_ENABLE_STATUS == $past(SW_ENABLE_DATA);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("enable bits not loaded");
    property p_off_low;
        !OUTPUT_RUNNING[0] ##1 !OUTPUT_RUNNING[0] |-> !DIFF_CLK_P[0] && !DIFF_CLK_N[0];
    endproperty
    a_off_low: assert property (p_off_low) else $error("stopped output not low");
    property p_run_toggle;
        OUTPUT_RUNNING[0] ##1 OUTPUT_RUNNING[0] |-> DIFF_CLK_P[0] != DIFF_CLK_N[0];
    endproperty
    a_run_toggle: assert property (p_run_toggle) else $error("running legs not complementary");
    property p_on_min;
        $rose(en0) && !OUTPUT_RUNNING[0] |-> !OUTPUT_RUNNING[0] [*8];
    endproperty
    a_on_min: assert property (p_on_min) else $error("output started too soon");
    property p_on_max;
        on_reg == 6'h18 |-> OUTPUT_RUNNING[0];
    endproperty
    a_on_max: assert property (p_on_max) else $error("output started too late");
    property p_off_min;
        $fell(en0) && POWER_DOWN_N && OUTPUT_RUNNING[0] |-> OUTPUT_RUNNING[0] [*8];
    endproperty
    a_off_min: assert property (p_off_min) else $error("output stopped too soon");
    property p_off_max;
        off_reg == 6'h18 |-> !OUTPUT_RUNNING[0] && !DIFF_CLK_P[0] && !DIFF_CLK_N[0];
    endproperty
    a_off_max: assert property (p_off_max) else $error("output stopped too late");
    property p_pd_stop;
        pd_reg == 5'd14 |-> OUTPUT_RUNNING == '0 && DIFF_CLK_P == '0 && DIFF_CLK_N == '0;
    endproperty
    a_pd_stop: assert property (p_pd_stop) else $error("power-down left outputs on");
    property p_osc_order;
        !OSC_ENABLE |-> OUTPUT_RUNNING == '0 && $past(OUTPUT_RUNNING) == '0;
    endproperty
    a_osc_order: assert property (p_osc_order) else $error("oscillator off before outputs");
    property p_rise_quiet;
        $rose(OUTPUT_RUNNING[0]) |-> (!DIFF_CLK_P[0] && DIFF_CLK_N[0]) ##1 (DIFF_CLK_P[0] && !DIFF_CLK_N[0]);
    endproperty
    a_rise_quiet: assert property (p_rise_quiet) else $error("gate opened mid pulse");
    c_start: cover property ($rose(OUTPUT_RUNNING[0]));
    c_stop: cover property ($fell(OUTPUT_RUNNING[0]));
    c_osc_off: cover property ($fell(OSC_ENABLE));
endmodule : clock_output_enable_gating_props
bind clock_output_enable_gating clock_output_enable_gating_props #(.NUM_OUTPUTS(NUM_OUTPUTS)) props_i (
    .MCLK(MCLK), .RST_N(RST_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .POWER_DOWN_N(POWER_DOWN_N),
    .SW_ENABLE_WE(SW_ENABLE_WE), .SW_ENABLE_DATA(SW_ENABLE_DATA), .SW_ENABLE_STATUS(SW_ENABLE_STATUS),
    .DIFF_CLK_P(DIFF_CLK_P), .DIFF_CLK_N(DIFF_CLK_N), .OUTPUT_RUNNING(OUTPUT_RUNNING), .OSC_ENABLE(OSC_ENABLE));
`default_nettype wire

// ### clk_sink.sv
`timescale 1ns/1ps
`default_nettype none
module clk_sink #(
    parameter int N = 6
) (
    // clock and count clear
    input wire logic clk,
    input wire logic clear,
    // legs from the buffer
    input wire logic [N-1:0] leg_p,
    input wire logic [N-1:0] leg_n,
    // rising edges seen, sticky overlap of both legs
    output logic [7:0] pulses [N],
    output logic overlap
);
    logic [N-1:0] p_last;
    // receiver counts rising true-leg edges per output
    always_ff @(posedge clk) begin
        p_last <= leg_p;
        overlap <= (clear ? 1'b0 : overlap) | (|(leg_p & leg_n));
        for (int i = 0; i < N; i++) begin
            if (clear) pulses[i] <= 8'h00;
            else if (leg_p[i] && !p_last[i]) pulses[i] <= pulses[i] + 8'h01;
        end
    end
endmodule : clk_sink
`default_nettype wire

// ### clock_output_enable_gating_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module clock_output_enable_gating_tb;
    localparam int NO = 6;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic [NO-1:0] oe_n = '1;
    logic pd_n = 1'b1;
    logic we = 1'b0;
    logic [NO-1:0] wdata = '0;
    logic [NO-1:0] sw_stat, p_leg, n_leg, running;
    logic osc, overlap;
    logic clear = 1'b0;
    logic [7:0] pulses [NO];
    logic [NO-1:0] sw_exp = '1;
    logic [NO-1:0] en_prev = '0;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    clock_output_enable_gating #(.NUM_OUTPUTS(NO)) clock_output_enable_gating_i (.MCLK(MCLK), .RST_N(RST_N),
        .OUTPUT_ENABLE_N(oe_n), .POWER_DOWN_N(pd_n), .SW_ENABLE_WE(we), .SW_ENABLE_DATA(wdata),
        .SW_ENABLE_STATUS(sw_stat), .DIFF_CLK_P(p_leg), .DIFF_CLK_N(n_leg), .OUTPUT_RUNNING(running),
        .OSC_ENABLE(osc));
    clk_sink #(.N(NO)) clk_sink_i (.clk(MCLK), .clear(clear), .leg_p(p_leg), .leg_n(n_leg),
        .pulses(pulses), .overlap(overlap));
    always #5 MCLK = ~MCLK;
    // hang guard
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    function automatic logic [NO-1:0] exp_run(input logic [NO-1:0] oe, input logic [NO-1:0] sw, input logic pd);
        return ~oe & sw & {NO{pd}};
    endfunction : exp_run
    // apply one input set, let it settle, judge outputs and received pulses
    task automatic segment(input logic [NO-1:0] oe, input logic w, input logic [NO-1:0] d, input logic pd);
        logic [NO-1:0] en_now;
        @(posedge MCLK);
        oe_n <= oe;
        pd_n <= pd;
        we <= w;
        wdata <= d;
        clear <= 1'b1;
        if (w) sw_exp = d;
        en_now = exp_run(oe, sw_exp, pd);
        @(posedge MCLK);
        we <= 1'b0;
        clear <= 1'b0;
        #1;
        `CHECK("sw_status", sw_exp, sw_stat)
        repeat (40) @(posedge MCLK);
        #1;
        `CHECK("running", en_now, running)
        `CHECK("osc", pd, osc)
        `CHECK("overlap", 1'b0, overlap)
        for (int i = 0; i < NO; i++) begin
            if (en_prev[i] && en_now[i]) `CHECK("steady", 1'b1, pulses[i] >= 8'd19)
            if (!en_prev[i] && !en_now[i]) `CHECK("quiet", 8'h00, pulses[i])
            if (!en_prev[i] && en_now[i]) `CHECK("start", 1'b1, pulses[i] inside {[6:18]})
            if (en_prev[i] && !en_now[i] && pd) `CHECK("tail", 1'b1, pulses[i] >= 8'd4)
        end
        en_prev = en_now;
    endtask : segment
    initial begin
        void'($urandom(32'h00e9));
        repeat (5) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        #1;
        `CHECK("sw_reset", 6'h3f, sw_stat)
        `CHECK("run_reset", 6'h00, running)
        // back-to-back writes, last one wins
        @(posedge MCLK);
        we <= 1'b1;
        wdata <= 6'h15;
        @(posedge MCLK);
        wdata <= 6'h3c;
        @(posedge MCLK);
        we <= 1'b0;
        #1;
        `CHECK("sw_b2b", 6'h3c, sw_stat)
        sw_exp = 6'h3c;
        segment(6'h00, 1'b0, 6'h00, 1'b1);
        segment(6'h00, 1'b1, 6'h2a, 1'b1);
        segment(6'h00, 1'b1, 6'h3f, 1'b0);
        segment(6'h00, 1'b0, 6'h00, 1'b1);
        segment(6'h3f, 1'b0, 6'h00, 1'b1);
        for (int k = 0; k < 150; k++) begin
            segment(NO'($urandom), $urandom_range(0, 3) == 0, NO'($urandom), $urandom_range(0, 7) != 0);
        end
        give_verdict();
    end
endmodule : clock_output_enable_gating_tb
`default_nettype wire
